//--- qpc_defines.svh
// Constants for the quad port controller host chain port.
// Assumes inclusion by bare name from the decoder, chain port and bench files.
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH

// ************************************************
// Frame layout
// ************************************************
`define QPC_FRAME_W 29
`define QPC_ALL_ONES 29'h1FFF_FFFF
`define QPC_RW_BIT 28
`define QPC_ADDR_HI 27
`define QPC_ADDR_LO 16
`define QPC_BUSY_BIT 15
`define QPC_NACK_BIT 13
`define QPC_REJ_BIT 12
`define QPC_DATA_HI 7
`define QPC_DATA_LO 0
`define QPC_CMD_LO 16
`define QPC_OFF_HI 23
`define QPC_IDX_HI 18

// ************************************************
// Address decoding
// ************************************************
`define QPC_LOCAL_PAGE 4'h8
`define QPC_PAGE_HI 11
`define QPC_PAGE_LO 8
`define QPC_PORT_HI 10
`define QPC_PORT_LO 9
`define QPC_DEV_BIT 8
`define QPC_TBL_TOP 8'h07
`define QPC_I2C_SELF_BASE 8'h04
`define QPC_I2C_PORT_BASE 8'h20

// ************************************************
// Reset values
// ************************************************
`define QPC_DEV0_DEF 8'hA0
`define QPC_DEV1_DEF 8'hA2
`define QPC_NUM_ENTRIES 8

`endif

//--- qpc_pkg.sv
// Types shared by the host chain port and its address decoder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package qpc_pkg;
    typedef enum logic [1:0] {
        QPC_OFF = 2'b00,
        QPC_IDLE = 2'b01,
        QPC_FRAME = 2'b10
    } qpc_state_t;

    typedef struct packed {
        logic local_win;
        logic port_win;
        logic [1:0] port;
        logic dev;
    } qpc_tgt_t;
endpackage : qpc_pkg
`default_nettype wire

//--- qpc_dec_if.sv
// Connection between the chain port and its address decoder.
// Assumes qpc_pkg is compiled first.
`default_nettype none
interface qpc_dec_if;
    import qpc_pkg::*;
    logic [11:0] addr;
    logic [7:0] i2c_addr;
    logic [3:0] inst;
    qpc_tgt_t tgt;
    logic self_hit;
    logic port_hit;
    logic [1:0] i2c_port;
    logic i2c_dev;

    modport host (output addr, i2c_addr, inst,
                  input tgt, self_hit, port_hit, i2c_port, i2c_dev);
    modport dec (input addr, i2c_addr, inst,
                 output tgt, self_hit, port_hit, i2c_port, i2c_dev);
endinterface : qpc_dec_if
`default_nettype wire

//--- qpc_addr_decode.sv
// Frame address and I2C address decoder, purely combinational.
// Assumes the instance number stays below 14.
`include "qpc_defines.svh"
`default_nettype none
module qpc_addr_decode
    import qpc_pkg::*;
(
    qpc_dec_if.dec dif
);
    logic [7:0] self_addr;
    logic [7:0] port_base;

    // ************************************************
    // Frame address windows
    // ************************************************
    always_comb begin
        dif.tgt.local_win =
            dif.addr[`QPC_PAGE_HI:`QPC_PAGE_LO] == `QPC_LOCAL_PAGE;
        dif.tgt.port_win = ~dif.addr[`QPC_PAGE_HI];
        dif.tgt.port = dif.addr[`QPC_PORT_HI:`QPC_PORT_LO];
        dif.tgt.dev = dif.addr[`QPC_DEV_BIT];
    end

    // ************************************************
    // I2C address map
    // ************************************************
    always_comb begin
        self_addr = `QPC_I2C_SELF_BASE + {3'h0, dif.inst, 1'b0};
        port_base = `QPC_I2C_PORT_BASE + {dif.inst, 4'h0};
        dif.self_hit = dif.i2c_addr[7:1] == self_addr[7:1];
        dif.port_hit = dif.i2c_addr[7:4] == port_base[7:4];
        dif.i2c_port = dif.i2c_addr[3:2];
        dif.i2c_dev = dif.i2c_addr[1];
    end
endmodule : qpc_addr_decode
`default_nettype wire

//--- qpc_chain_port.sv
// Host chain port: serial daisy-chain slave with frame execution.
// Assumes host pins are asynchronous and SCK is well under mclk / 4.
`include "qpc_defines.svh"
`default_nettype none
// Contract
// - On select rising, latch and execute the frame in the shift register.
// - Select high: ignore data in, serial output undriven.
// - Shifting in a new frame shifts out the previous frame.
// - Output enable follows select low combinationally in serial mode; it stays low in I2C mode.
// - Twelve-bit address gives each port and device its own window.
// - Port 0 dev 0 at 0x000, dev 1 at 0x100, locals at 0x800.
// - I2C self address 0x04+2k; devices 0x20+16k+4p+2d.
// - Downstream device addresses programmable, defaults 0xA0 and 0xA2.
// - No chain length limit; latency grows with chain length.
// - 29-bit frame: bit 28 read flag first, address, data last.
// - Reads return busy bit 15, nack bit 13, reject bit 12.
// - Strap low selects serial mode, else I2C mode.
// - Reads take two frames; all-ones frame does nothing.
module qpc_chain_port
    import qpc_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Host pins
    input wire logic i_host_pin_one,
    input wire logic i_host_pin_two_n,
    input wire logic i_host_pin_three,
    output logic o_host_pin_four,
    output logic o_host_pin_four_oe,
    // Strap and mode
    input wire logic i_proto_sel,
    output logic o_spi_mode,
    // I2C address match
    input wire logic [7:0] i_i2c_addr,
    input wire logic [3:0] i_instance,
    output logic o_i2c_self_hit,
    output logic o_i2c_port_hit,
    output logic [1:0] o_i2c_port,
    output logic o_i2c_dev,
    // Downstream request
    output logic o_req_valid,
    output logic o_req_read,
    output logic o_req_local,
    output logic [1:0] o_req_port,
    output logic o_req_dev,
    output logic [7:0] o_req_offset,
    output logic [7:0] o_req_wdata,
    input wire logic i_req_ready,
    // Downstream response
    input wire logic i_rsp_valid,
    input wire logic [7:0] i_rsp_rdata,
    input wire logic i_rsp_nack,
    // Device address table
    output logic [7:0] o_dev_addr [`QPC_NUM_ENTRIES]
);
    qpc_state_t state, next_state;
    logic [2:0] sck_p, ss_p, mosi_p, strap_p;
    logic sck_d, next_sck_d;
    logic [`QPC_FRAME_W-1:0] shreg, next_shreg;
    logic miso, next_miso;
    logic taken, next_taken;
    logic spi_mode, next_spi_mode;
    logic pending, next_pending;
    logic rsp_hold, next_rsp_hold;
    logic [7:0] rsp_data, next_rsp_data;
    logic rsp_nack, next_rsp_nack;
    logic req_valid, next_req_valid;
    logic req_read, next_req_read;
    logic req_local, next_req_local;
    logic [1:0] req_port, next_req_port;
    logic req_dev, next_req_dev;
    logic [7:0] req_offset, next_req_offset;
    logic [7:0] req_wdata, next_req_wdata;
    logic tbl_we;
    logic [2:0] tbl_idx;
    logic [7:0] dev_addr [`QPC_NUM_ENTRIES];
    logic [7:0] next_dev [`QPC_NUM_ENTRIES];
    logic sck_s, ss_s, mosi_s, sck_rise, sck_fall, merge, closing;
    logic [7:0] frm_off;
    logic [7:0] frm_data;
    logic i2c_self, i2c_port_hit, i2c_dev;
    logic [1:0] i2c_port;

    qpc_dec_if dif ();

    qpc_addr_decode u_dec (
        .dif(dif)
    );

    // ************************************************
    // Pin synchronisers
    // ************************************************
    always_ff @(posedge i_mclk) begin
        sck_p <= {sck_p[1:0], i_host_pin_one};
        ss_p <= {ss_p[1:0], i_host_pin_two_n};
        mosi_p <= {mosi_p[1:0], i_host_pin_three};
        strap_p <= {strap_p[1:0], i_proto_sel};
    end

    // Stage 1 of each chain feeds stage 2 only
    assign sck_s = sck_p[1];
    assign ss_s = ss_p[1];
    assign mosi_s = mosi_p[1];
    assign sck_rise = sck_s & ~sck_d;
    assign sck_fall = ~sck_s & sck_d;
    assign merge = (state == QPC_IDLE) && rsp_hold && pending;
    assign closing = (state == QPC_FRAME) && ss_s;
    assign frm_off = shreg[`QPC_OFF_HI:`QPC_ADDR_LO];
    assign frm_data = shreg[`QPC_DATA_HI:`QPC_DATA_LO];
    assign dif.addr = shreg[`QPC_ADDR_HI:`QPC_ADDR_LO];
    assign dif.i2c_addr = i_i2c_addr;
    assign dif.inst = i_instance;

    // ************************************************
    // Chain shifter and frame execution
    // ************************************************
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_miso = miso;
        next_sck_d = sck_s;
        next_taken = 1'b1;
        next_spi_mode = spi_mode;
        next_req_valid = 1'b0;
        next_req_read = req_read;
        next_req_local = req_local;
        next_req_port = req_port;
        next_req_dev = req_dev;
        next_req_offset = req_offset;
        next_req_wdata = req_wdata;
        next_pending = pending & ~merge;
        next_rsp_hold = i_rsp_valid | (rsp_hold & pending & ~merge);
        next_rsp_data = i_rsp_valid ? i_rsp_rdata : rsp_data;
        next_rsp_nack = i_rsp_valid ? i_rsp_nack : rsp_nack;
        tbl_we = 1'b0;
        tbl_idx = shreg[`QPC_IDX_HI:`QPC_ADDR_LO];
        if (!taken) begin
            next_spi_mode = ~strap_p[2];
        end
        unique case (state)
            QPC_OFF: begin
                if (taken && spi_mode && ss_s) begin
                    next_state = QPC_IDLE;
                end
            end
            QPC_IDLE: begin
                if (merge) begin
                    next_shreg[`QPC_BUSY_BIT:`QPC_DATA_LO] =
                        {2'b00, rsp_nack, 5'h00, rsp_data};
                end
                if (!ss_s) begin
                    next_state = QPC_FRAME;
                    next_miso = shreg[`QPC_RW_BIT];
                end
            end
            QPC_FRAME: begin
                if (sck_rise) begin
                    next_shreg = {shreg[`QPC_FRAME_W-2:0], mosi_s};
                end
                if (sck_fall) begin
                    next_miso = shreg[`QPC_RW_BIT];
                end
                if (ss_s) begin
                    next_state = QPC_IDLE;
                    next_shreg = shreg;
                    if (shreg == `QPC_ALL_ONES) begin
                        next_state = QPC_IDLE;
                    end else if (dif.tgt.local_win &&
                                 frm_off <= `QPC_TBL_TOP) begin
                        if (shreg[`QPC_RW_BIT]) begin
                            next_shreg[`QPC_BUSY_BIT:`QPC_DATA_LO] =
                                {8'h00, dev_addr[tbl_idx]};
                        end else begin
                            tbl_we = 1'b1;
                        end
                    end else if (!dif.tgt.local_win &&
                                 !dif.tgt.port_win) begin
                        next_state = QPC_IDLE;
                    end else if (!i_req_ready) begin
                        next_shreg[`QPC_REJ_BIT] = 1'b1;
                    end else begin
                        next_req_valid = 1'b1;
                        next_req_read = shreg[`QPC_RW_BIT];
                        next_req_local = dif.tgt.local_win;
                        next_req_port = dif.tgt.port;
                        next_req_dev = dif.tgt.dev;
                        next_req_offset = frm_off;
                        next_req_wdata = frm_data;
                        if (shreg[`QPC_RW_BIT]) begin
                            next_pending = 1'b1;
                            next_shreg[`QPC_BUSY_BIT] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_state = QPC_OFF;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state <= QPC_OFF;
            shreg <= '0;
            miso <= 1'b0;
            sck_d <= 1'b0;
            taken <= 1'b0;
            spi_mode <= 1'b0;
            pending <= 1'b0;
            rsp_hold <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nack <= 1'b0;
            req_valid <= 1'b0;
            req_read <= 1'b0;
            req_local <= 1'b0;
            req_port <= 2'h0;
            req_dev <= 1'b0;
            req_offset <= 8'h00;
            req_wdata <= 8'h00;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            miso <= next_miso;
            sck_d <= next_sck_d;
            taken <= next_taken;
            spi_mode <= next_spi_mode;
            pending <= next_pending;
            rsp_hold <= next_rsp_hold;
            rsp_data <= next_rsp_data;
            rsp_nack <= next_rsp_nack;
            req_valid <= next_req_valid;
            req_read <= next_req_read;
            req_local <= next_req_local;
            req_port <= next_req_port;
            req_dev <= next_req_dev;
            req_offset <= next_req_offset;
            req_wdata <= next_req_wdata;
        end
    end

    // ************************************************
    // Downstream device address table
    // ************************************************
    for (genvar gi = 0; gi < `QPC_NUM_ENTRIES; gi++) begin : g_tbl
        always_comb begin
            next_dev[gi] = (tbl_we && tbl_idx == 3'(gi)) ?
                frm_data : dev_addr[gi];
        end
        always_ff @(posedge i_mclk) begin
            if (!i_reset_n) begin
                dev_addr[gi] <= (gi % 2 == 1) ?
                    `QPC_DEV1_DEF : `QPC_DEV0_DEF;
            end else begin
                dev_addr[gi] <= next_dev[gi];
            end
        end
    end

    // ************************************************
    // I2C match outputs
    // ************************************************
    always_comb begin
        i2c_self = dif.self_hit & ~spi_mode & taken;
        i2c_port_hit = dif.port_hit & ~spi_mode & taken;
        i2c_port = dif.i2c_port;
        i2c_dev = dif.i2c_dev;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_i2c_self_hit <= 1'b0;
            o_i2c_port_hit <= 1'b0;
            o_i2c_port <= 2'h0;
            o_i2c_dev <= 1'b0;
        end else begin
            o_i2c_self_hit <= i2c_self;
            o_i2c_port_hit <= i2c_port_hit;
            o_i2c_port <= i2c_port;
            o_i2c_dev <= i2c_dev;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign o_host_pin_four_oe = spi_mode & ~i_host_pin_two_n;
    assign o_host_pin_four = miso;
    assign o_spi_mode = spi_mode;
    assign o_req_valid = req_valid;
    assign o_req_read = req_read;
    assign o_req_local = req_local;
    assign o_req_port = req_port;
    assign o_req_dev = req_dev;
    assign o_req_offset = req_offset;
    assign o_req_wdata = req_wdata;
    assign o_dev_addr = dev_addr;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_oe_select: assert property (
        o_host_pin_four_oe == (spi_mode && !i_host_pin_two_n))
        else $error("output enable does not follow select");
    a_req_close: assert property (
        o_req_valid |-> $past(closing) && state == QPC_IDLE)
        else $error("request without select rising");
    a_shift_rise: assert property (
        (state == QPC_FRAME && sck_rise && !ss_s)
        |=> shreg[0] == $past(mosi_s) && shreg[28:1] == $past(shreg[27:0]))
        else $error("shift register did not take data in");
    a_drive_fall: assert property (
        (state == QPC_FRAME && sck_fall && !ss_s)
        |=> o_host_pin_four == $past(shreg[`QPC_RW_BIT]))
        else $error("serial output not updated on falling edge");
    a_idle_quiet: assert property (
        (state == QPC_IDLE && !merge) |=> $stable(shreg))
        else $error("shift register moved while deselected");
    a_dummy_ignored: assert property (
        (closing && shreg == `QPC_ALL_ONES)
        |=> !o_req_valid && shreg == `QPC_ALL_ONES)
        else $error("all-ones frame caused an action");
    a_read_busy: assert property (
        (o_req_valid && o_req_read) |-> shreg[`QPC_BUSY_BIT] && pending)
        else $error("remote read not flagged busy");
    a_reject_flag: assert property (
        (closing && !i_req_ready && dif.tgt.port_win &&
         shreg != `QPC_ALL_ONES)
        |=> shreg[`QPC_REJ_BIT] && !o_req_valid)
        else $error("refused command not flagged");
    a_tbl_reset: assert property (
        $rose(i_reset_n) |-> dev_addr[0] == `QPC_DEV0_DEF &&
        dev_addr[1] == `QPC_DEV1_DEF)
        else $error("device address defaults wrong");
    a_strap_mode: assert property (
        $rose(taken) |-> spi_mode == !$past(strap_p[2], 1))
        else $error("strap not captured");

    c_write: cover property (o_req_valid && !o_req_read);
    c_read: cover property (o_req_valid && o_req_read ##[1:1000] merge);
    c_dummy: cover property (closing && shreg == `QPC_ALL_ONES);
    c_reject: cover property (closing && !i_req_ready);
endmodule : qpc_chain_port
`default_nettype wire

//--- qpc_host_bfm.sv
// Host serial master model for one controller on the chain.
// Assumes the bench samples nothing it drives; SCK idles low.
`default_nettype none
module qpc_host_bfm (
    // Clock
    input wire logic i_mclk,
    // Chain return
    input wire logic i_miso,
    input wire logic i_miso_oe,
    // Chain drive
    output logic o_sck,
    output logic o_ss_n,
    output logic o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;

    logic oe_seen;

    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b0;
        oe_seen = 1'b0;
    end

    // Data line churns while deselected
    always @(posedge i_mclk) begin
        if (o_ss_n) begin
            o_mosi <= ~o_mosi;
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask : wait_clk

    // One controller on the chain: host out to its input, its output back
    task automatic frame(input logic [28:0] tx, output logic [28:0] rx);
        wait_clk(1);
        o_ss_n = 1'b0;
        #1 oe_seen = i_miso_oe;
        wait_clk(4);
        for (int i = 28; i >= 0; i--) begin
            o_mosi = tx[i];
            wait_clk(5);
            rx[i] = i_miso;
            o_sck = 1'b1;
            wait_clk(5);
            o_sck = 1'b0;
        end
        wait_clk(5);
        o_ss_n = 1'b1;
        wait_clk(8);
    endtask : frame
endmodule : qpc_host_bfm
`default_nettype wire

//--- test_spi_chain_host_port.sv
// Self-checking bench for the host chain port.
// Assumes qpc_pkg, qpc_dec_if, decoder, port and host model compiled.
`include "qpc_defines.svh"
`default_nettype none
module test_spi_chain_host_port;
    timeunit 1ns;
    timeprecision 1ps;

    `define QPB_CHK(got, exp) \
        begin \
            num_checks++; \
            if ((got) !== (exp)) begin \
                n_mismatch++; \
                $display("[FAIL] %0t ns got %h exp %h", $time, got, exp); \
            end \
        end

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic sck, ss_n, mosi, four, four_oe, proto_sel, spi_mode;
    wire logic miso;
    logic [7:0] i2c_addr;
    logic [3:0] inst;
    logic self_hit, port_hit, i2c_dev, req_valid, req_read, req_local;
    logic [1:0] i2c_port, req_port;
    logic req_dev;
    logic [7:0] req_offset, req_wdata, rsp_rdata;
    logic req_ready, rsp_valid, rsp_nack;
    logic [7:0] dev_addr [`QPC_NUM_ENTRIES];
    logic [28:0] rx;
    int n_mismatch = 0, num_checks = 0, n_req = 0;

    assign miso = four_oe ? four : ~four;

    initial begin
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (req_valid === 1'b1) begin
            n_req <= n_req + 1;
        end
    end

    qpc_chain_port qpc_chain_port_i (
        .i_mclk(mclk), .i_reset_n(reset_n),
        .i_host_pin_one(sck), .i_host_pin_two_n(ss_n),
        .i_host_pin_three(mosi), .o_host_pin_four(four),
        .o_host_pin_four_oe(four_oe), .i_proto_sel(proto_sel),
        .o_spi_mode(spi_mode), .i_i2c_addr(i2c_addr), .i_instance(inst),
        .o_i2c_self_hit(self_hit), .o_i2c_port_hit(port_hit),
        .o_i2c_port(i2c_port), .o_i2c_dev(i2c_dev),
        .o_req_valid(req_valid), .o_req_read(req_read),
        .o_req_local(req_local), .o_req_port(req_port), .o_req_dev(req_dev),
        .o_req_offset(req_offset), .o_req_wdata(req_wdata),
        .i_req_ready(req_ready), .i_rsp_valid(rsp_valid),
        .i_rsp_rdata(rsp_rdata), .i_rsp_nack(rsp_nack),
        .o_dev_addr(dev_addr)
    );

    qpc_host_bfm qpc_host_bfm_i (
        .i_mclk(mclk), .i_miso(miso), .i_miso_oe(four_oe),
        .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic xfer(input logic [28:0] tx);
        qpc_host_bfm_i.frame(tx, rx);
    endtask : xfer

    task automatic do_reset(input logic strap);
        @(posedge mclk);
        #2 proto_sel = strap;
        i2c_addr = 8'h00;
        inst = 4'h0;
        req_ready = 1'b1;
        rsp_valid = 1'b0;
        rsp_rdata = 8'h00;
        rsp_nack = 1'b0;
        reset_n = 1'b0;
        qpc_host_bfm_i.wait_clk(16);
        reset_n = 1'b1;
        qpc_host_bfm_i.wait_clk(6);
    endtask : do_reset

    task automatic t_reset();
        `QPB_CHK(spi_mode, 1'b1)
        `QPB_CHK(four_oe, 1'b0)
        for (int i = 0; i < 8; i++) begin
            `QPB_CHK(dev_addr[i], (i % 2) ? 8'hA2 : 8'hA0)
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_windows();
        logic [28:0] tx, prev;
        logic [2:0] pd;
        for (int i = 0; i < 8; i++) begin
            pd = 3'(i);
            prev = tx;
            tx = {1'b0, 1'b0, pd, 8'(16 + i), 8'h00, 8'(8'hC0 + i)};
            xfer(tx);
            `QPB_CHK(n_req, i + 1)
            `QPB_CHK({req_read, req_local}, 2'b00)
            `QPB_CHK({req_port, req_dev}, pd)
            `QPB_CHK(req_offset, 8'(16 + i))
            `QPB_CHK(req_wdata, 8'(8'hC0 + i))
            `QPB_CHK(qpc_host_bfm_i.oe_seen, 1'b1)
            if (i > 0) begin
                `QPB_CHK(rx, prev)
            end
        end
        `QPB_CHK(four_oe, 1'b0)
        $display("test windows done");
    endtask : t_windows

    task automatic t_local();
        int n0;
        n0 = n_req;
        xfer({1'b0, 12'h803, 8'h00, 8'h5A});
        `QPB_CHK(dev_addr[3], 8'h5A)
        xfer({1'b1, 12'h803, 8'h00, 8'h00});
        `QPB_CHK(rx, {1'b0, 12'h803, 8'h00, 8'h5A})
        xfer(`QPC_ALL_ONES);
        `QPB_CHK(rx, {1'b1, 12'h803, 8'h00, 8'h5A})
        `QPB_CHK(n_req, n0)
        xfer({1'b0, 12'h8A0, 8'h00, 8'h77});
        `QPB_CHK({req_local, req_offset, req_wdata}, 17'h1A077)
        $display("test local done");
    endtask : t_local

    task automatic t_remote_read();
        xfer({1'b1, 12'h512, 8'h00, 8'h00});
        `QPB_CHK({req_read, req_local, req_port, req_dev}, 5'b10101)
        `QPB_CHK(req_offset, 8'h12)
        xfer(`QPC_ALL_ONES);
        `QPB_CHK(rx, {1'b1, 12'h512, 8'h80, 8'h00})
        @(posedge mclk);
        #2 rsp_valid = 1'b1;
        rsp_rdata = 8'h3C;
        rsp_nack = 1'b1;
        qpc_host_bfm_i.wait_clk(1);
        rsp_valid = 1'b0;
        qpc_host_bfm_i.wait_clk(3);
        xfer(`QPC_ALL_ONES);
        `QPB_CHK({rx[15], rx[13], rx[7:0]}, 10'b01_0011_1100)
        $display("test remote read done");
    endtask : t_remote_read

    task automatic t_reject();
        int n0;
        n0 = n_req;
        req_ready = 1'b0;
        xfer({1'b0, 12'h100, 8'h00, 8'h11});
        `QPB_CHK(n_req, n0)
        req_ready = 1'b1;
        xfer(`QPC_ALL_ONES);
        `QPB_CHK(rx, {1'b0, 12'h100, 8'h10, 8'h11})
        $display("test reject done");
    endtask : t_reject

    task automatic t_i2c();
        do_reset(1'b1);
        `QPB_CHK(spi_mode, 1'b0)
        xfer(`QPC_ALL_ONES);
        `QPB_CHK(qpc_host_bfm_i.oe_seen, 1'b0)
        for (int k = 0; k < 14; k++) begin
            inst = 4'(k);
            i2c_addr = 8'(4 + 2 * k);
            qpc_host_bfm_i.wait_clk(2);
            `QPB_CHK({self_hit, port_hit}, 2'b10)
            for (int j = 0; j < 8; j++) begin
                i2c_addr = 8'(32 + 16 * k + 2 * j);
                qpc_host_bfm_i.wait_clk(2);
                `QPB_CHK({self_hit, port_hit}, 2'b01)
                `QPB_CHK({i2c_port, i2c_dev}, 3'(j))
            end
        end
        $display("test i2c done");
    endtask : t_i2c

    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        $display("[FAIL] %0t ns watchdog expired", $time);
        end_sim();
    end

    initial begin
        do_reset(1'b0);
        t_reset();
        t_windows();
        t_local();
        t_remote_read();
        t_reject();
        t_i2c();
        end_sim();
    end
endmodule : test_spi_chain_host_port
`default_nettype wire
